/* src/lim_pkg.sv */
package lim_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [7:0]  OFS_CAP_HDR    = 8'h78;
  localparam logic [7:0]  OFS_DATA_WIN   = 8'h7c;
  localparam logic [7:0]  OFS_DEF_BASE   = 8'ha0;
  localparam logic [7:0]  OFS_DEF_LAST   = 8'haf;

  // ------------------------------------------------------------------
  // Definition entry layout
  // ------------------------------------------------------------------
  localparam int          NUM_PINS       = 8;
  localparam logic [7:0]  IDX_LIMIT      = 8'h08;
  localparam int          DEF_EN_BIT     = 15;
  localparam int          DEF_DMODE_BIT  = 14;
  localparam int          DEF_DID_MSB    = 13;
  localparam int          DEF_DID_LSB    = 6;
  localparam int          DEF_TYPE_MSB   = 5;
  localparam int          DEF_TYPE_LSB   = 4;
  localparam int          DEF_POL_BIT    = 3;
  localparam int          DEF_TRIG_BIT   = 2;
  localparam int          DEF_VEC_MSB    = 1;
  localparam int          DEF_VEC_LSB    = 0;
  localparam logic [15:0] DEF_RESET      = 16'h3fc0;
  localparam logic [15:0] DEF_WARM_KEEP  = 16'hffc8;

  // ------------------------------------------------------------------
  // Capability header constants and reset values
  // ------------------------------------------------------------------
  localparam logic [7:0]  CAP_TYPE_VAL   = 8'h80;
  localparam logic [7:0]  CAP_NEXT_VAL   = 8'hb4;
  localparam logic [7:0]  CAP_ID_VAL     = 8'h08;
  localparam logic [7:0]  INDEX_RESET    = 8'h00;

  typedef enum logic [1:0] {
    legacy_single_mode,
    legacy_dual_mode,
    generic_single_mode,
    generic_dual_mode
  } lim_mode_t;

  function automatic logic lim_is_legacy(input lim_mode_t m);
    return (m == legacy_single_mode) || (m == legacy_dual_mode);
  endfunction : lim_is_legacy

  function automatic logic lim_is_generic(input lim_mode_t m);
    return (m == generic_single_mode) || (m == generic_dual_mode);
  endfunction : lim_is_generic

  function automatic logic lim_def_hit(input logic [7:0] a);
    return (a >= OFS_DEF_BASE) && (a <= OFS_DEF_LAST) && (a[1:0] == 2'b00);
  endfunction : lim_def_hit

endpackage : lim_pkg

/* src/lim_top.sv */
// Function
// - Eight 16-bit pin definitions, four pairs of two, at bytes A0 to AF.
// - Pin definition locations work only in legacy modes, else read zero, ignore writes.
// - Bit 15 enables the pin's messages; resets to zero.
// - Bit 14 picks physical or logical destination; bits 13:6 destination, reset all ones.
// - Bits 5:4 message type fixed, arbitrated, SMI, NMI; warm reset clears.
// - Bit 3 polarity: zero active low, one active high; resets zero.
// - Bit 2 trigger: zero edge, one level; warm reset clears.
// - Bits 1:0 vector zero to three; warm reset clears.
// - Capability header and data window work only in generic modes.
// - Header bits 31:24 read constant 80h, read only.
// - Header bits 7:0 read 08h, bits 15:8 read B4h, read only.
// - Header bits 23:16 writable index, reset zero, selects window entry.
// - Data window at 7C forwards reads and writes to indexed entry.
`timescale 1ns/10ps
`default_nettype none

module lim_top
  import lim_pkg::*;
(
  // Clock and resets
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        warm_reset,
  // Operating mode
  input  wire lim_mode_t   mode,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Interrupt pins
  input  wire logic [7:0]  irq_pin,
  // Message out
  output logic             msg_valid,
  input  wire logic        msg_ready,
  output logic      [2:0]  msg_pin,
  output logic             msg_dest_mode,
  output logic      [7:0]  msg_dest_id,
  output logic      [1:0]  msg_type,
  output logic             msg_trigger,
  output logic      [1:0]  msg_vector
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0][15:0] defs;
    logic [7:0]       index;
    logic [7:0]       act;
    logic [7:0]       pend;
    logic             valid;
    logic [2:0]       pin;
    logic             dmode;
    logic [7:0]       did;
    logic [1:0]       mtype;
    logic             trig;
    logic [1:0]       vec;
    logic [31:0]      rdata;
  } lim_state_t;

  lim_state_t st_q;
  lim_state_t st_d;

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    logic [7:0] act_now;
    logic [7:0] rise;
    logic [7:0] grant;
    logic [2:0] sel;
    logic       found;
    logic [2:0] pair_lo;
    logic [2:0] pair_hi;
    act_now = '0;
    rise    = '0;
    grant   = '0;
    sel     = '0;
    found   = 1'b0;
    pair_lo = {reg_addr[3:2], 1'b0};
    pair_hi = {reg_addr[3:2], 1'b1};
    st_d    = st_q;

    // Read data stands for exactly one cycle
    st_d.rdata = '0;
    if (reg_rd) begin
      if (reg_addr == OFS_CAP_HDR && lim_is_generic(mode)) begin
        st_d.rdata = {CAP_TYPE_VAL, st_q.index, CAP_NEXT_VAL, CAP_ID_VAL};
      end else if (reg_addr == OFS_DATA_WIN && lim_is_generic(mode)) begin
        if (st_q.index < IDX_LIMIT) begin
          st_d.rdata = {16'h0000, st_q.defs[st_q.index[2:0]]};
        end
      end else if (lim_def_hit(reg_addr) && lim_is_legacy(mode)) begin
        st_d.rdata = {st_q.defs[pair_hi], st_q.defs[pair_lo]};
      end
    end

    // Writes; reserved locations swallow them
    if (reg_wr) begin
      if (reg_addr == OFS_CAP_HDR && lim_is_generic(mode)) begin
        st_d.index = reg_wdata[23:16];
      end else if (reg_addr == OFS_DATA_WIN && lim_is_generic(mode)) begin
        if (st_q.index < IDX_LIMIT) begin
          st_d.defs[st_q.index[2:0]] = reg_wdata[15:0];
        end
      end else if (lim_def_hit(reg_addr) && lim_is_legacy(mode)) begin
        st_d.defs[pair_lo] = reg_wdata[15:0];
        st_d.defs[pair_hi] = reg_wdata[31:16];
      end
    end

    // Pin activity: polarity decides the active level
    for (int i = 0; i < NUM_PINS; i++) begin
      act_now[i] = st_q.defs[i][DEF_POL_BIT] ? irq_pin[i] : ~irq_pin[i];
      rise[i]    = act_now[i] & ~st_q.act[i] & st_q.defs[i][DEF_EN_BIT];
    end
    st_d.act = act_now;

    // Message issue, lowest pin first
    if (st_q.valid && msg_ready) begin
      st_d.valid = 1'b0;
    end
    if (!st_q.valid) begin
      for (int i = NUM_PINS - 1; i >= 0; i--) begin
        if (st_q.pend[i]) begin
          sel   = 3'(i);
          found = 1'b1;
        end
      end
      if (found) begin
        grant[sel]  = 1'b1;
        st_d.valid  = 1'b1;
        st_d.pin    = sel;
        st_d.dmode  = st_q.defs[sel][DEF_DMODE_BIT];
        st_d.did    = st_q.defs[sel][DEF_DID_MSB:DEF_DID_LSB];
        st_d.mtype  = st_q.defs[sel][DEF_TYPE_MSB:DEF_TYPE_LSB];
        st_d.trig   = st_q.defs[sel][DEF_TRIG_BIT];
        st_d.vec    = st_q.defs[sel][DEF_VEC_MSB:DEF_VEC_LSB];
      end
    end
    // A new edge in the grant cycle re-arms the pin
    st_d.pend = (st_q.pend & ~grant) | rise;

    // Warm reset: only the non-persistent fields, plus in-flight messages
    if (warm_reset) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        st_d.defs[i] = st_d.defs[i] & DEF_WARM_KEEP;
      end
      st_d.pend  = '0;
      st_d.valid = 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_q       <= '0;
      st_q.defs  <= {NUM_PINS{DEF_RESET}};
      st_q.index <= INDEX_RESET;
      st_q.act   <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata     = st_q.rdata;
  assign msg_valid     = st_q.valid;
  assign msg_pin       = st_q.pin;
  assign msg_dest_mode = st_q.dmode;
  assign msg_dest_id   = st_q.did;
  assign msg_type      = st_q.mtype;
  assign msg_trigger   = st_q.trig;
  assign msg_vector    = st_q.vec;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  logic       warm_fields_set;
  logic [7:0] en_vec;
  // Enables gathered once so one property covers every pin
  always_comb begin
    warm_fields_set = 1'b0;
    en_vec          = '0;
    for (int i = 0; i < NUM_PINS; i++) begin
      warm_fields_set = warm_fields_set | (|(st_q.defs[i] & ~DEF_WARM_KEEP & ~16'h0008));
      en_vec[i]       = st_q.defs[i][DEF_EN_BIT];
    end
  end

  property p_hdr_type;
    @(posedge clock) disable iff (!reset_n)
      (reg_rd && reg_addr == OFS_CAP_HDR && lim_is_generic(mode))
      |=> (reg_rdata[31:24] == 8'h80);
  endproperty
  a_hdr_type: assert property (p_hdr_type) else $error("header type field wrong");

  property p_hdr_id_next;
    @(posedge clock) disable iff (!reset_n)
      (reg_rd && reg_addr == OFS_CAP_HDR && lim_is_generic(mode))
      |=> (reg_rdata[7:0] == 8'h08) && (reg_rdata[15:8] == 8'hb4);
  endproperty
  a_hdr_id_next: assert property (p_hdr_id_next) else $error("header id or next wrong");

  property p_def_reserved;
    @(posedge clock) disable iff (!reset_n)
      (reg_rd && lim_def_hit(reg_addr) && lim_is_generic(mode)) |=> (reg_rdata == 32'h0);
  endproperty
  a_def_reserved: assert property (p_def_reserved) else $error("definition not reserved");

  property p_cap_reserved;
    @(posedge clock) disable iff (!reset_n)
      (reg_rd && (reg_addr == OFS_CAP_HDR || reg_addr == OFS_DATA_WIN) && lim_is_legacy(mode))
      |=> (reg_rdata == 32'h0);
  endproperty
  a_cap_reserved: assert property (p_cap_reserved) else $error("capability not reserved");

  property p_index_write;
    @(posedge clock) disable iff (!reset_n)
      (reg_wr && reg_addr == OFS_CAP_HDR && lim_is_generic(mode))
      |=> (st_q.index == $past(reg_wdata[23:16]));
  endproperty
  a_index_write: assert property (p_index_write) else $error("index not written");

  property p_window_write;
    @(posedge clock) disable iff (!reset_n)
      (reg_wr && reg_addr == OFS_DATA_WIN && lim_is_generic(mode)
       && st_q.index < IDX_LIMIT && !warm_reset)
      |=> (st_q.defs[$past(st_q.index[2:0])] == $past(reg_wdata[15:0]));
  endproperty
  a_window_write: assert property (p_window_write) else $error("window write lost");

  property p_warm_clear;
    @(posedge clock) disable iff (!reset_n)
      warm_reset |=> !warm_fields_set && !msg_valid;
  endproperty
  a_warm_clear: assert property (p_warm_clear) else $error("warm fields kept");

  property p_warm_keep;
    @(posedge clock) disable iff (!reset_n)
      (warm_reset && !reg_wr)
      |=> (st_q.defs[0][15:6] == $past(st_q.defs[0][15:6]))
          && (st_q.defs[0][DEF_POL_BIT] == $past(st_q.defs[0][DEF_POL_BIT]));
  endproperty
  a_warm_keep: assert property (p_warm_keep) else $error("persistent field lost");

  property p_enable_gate;
    @(posedge clock) disable iff (!reset_n)
      (!st_q.defs[0][DEF_EN_BIT] && !st_q.pend[0]) |=> !st_q.pend[0];
  endproperty
  a_enable_gate: assert property (p_enable_gate) else $error("disabled pin armed");

  property p_pend_cause;
    @(posedge clock) disable iff (!reset_n)
      $rose(st_q.pend[0]) |-> st_q.act[0] && !$past(st_q.act[0])
                              && ($past(irq_pin[0]) == $past(st_q.defs[0][DEF_POL_BIT]));
  endproperty
  a_pend_cause: assert property (p_pend_cause) else $error("pin armed without activation");

  property p_msg_hold;
    @(posedge clock) disable iff (!reset_n || warm_reset)
      (msg_valid && !msg_ready) |=> msg_valid && $stable(msg_pin) && $stable(msg_vector)
                                    && $stable(msg_dest_id);
  endproperty
  a_msg_hold: assert property (p_msg_hold) else $error("message dropped before accept");

  property p_msg_issue;
    @(posedge clock) disable iff (!reset_n || warm_reset)
      (!msg_valid && st_q.pend[0]) |=> msg_valid && (msg_pin == 3'h0);
  endproperty
  a_msg_issue: assert property (p_msg_issue) else $error("pending pin not sent");

  property p_window_read;
    @(posedge clock) disable iff (!reset_n)
      (reg_rd && reg_addr == OFS_DATA_WIN && lim_is_generic(mode) && st_q.index < IDX_LIMIT)
      |=> (reg_rdata == {16'h0000, $past(st_q.defs[st_q.index[2:0]])});
  endproperty
  a_window_read: assert property (p_window_read) else $error("window read wrong");

  property p_window_range;
    @(posedge clock) disable iff (!reset_n)
      (reg_rd && reg_addr == OFS_DATA_WIN && lim_is_generic(mode) && st_q.index >= IDX_LIMIT)
      |=> (reg_rdata == 32'h0);
  endproperty
  a_window_range: assert property (p_window_range) else $error("window index range");

  property p_legacy_read;
    @(posedge clock) disable iff (!reset_n)
      (reg_rd && lim_def_hit(reg_addr) && lim_is_legacy(mode))
      |=> (reg_rdata == {$past(st_q.defs[{reg_addr[3:2], 1'b1}]),
                         $past(st_q.defs[{reg_addr[3:2], 1'b0}])});
  endproperty
  a_legacy_read: assert property (p_legacy_read) else $error("definition pair misread");

  property p_unmapped_zero;
    @(posedge clock) disable iff (!reset_n)
      (reg_rd && reg_addr != OFS_CAP_HDR && reg_addr != OFS_DATA_WIN && !lim_def_hit(reg_addr))
      |=> (reg_rdata == 32'h0);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read");

  // Pin 0 alone: its fields can be traced without a priority model
  property p_msg_fields;
    @(posedge clock) disable iff (!reset_n || warm_reset)
      (!msg_valid && st_q.pend[0])
      |=> (msg_dest_mode == $past(st_q.defs[0][DEF_DMODE_BIT]))
          && (msg_dest_id == $past(st_q.defs[0][DEF_DID_MSB:DEF_DID_LSB]))
          && (msg_type == $past(st_q.defs[0][DEF_TYPE_MSB:DEF_TYPE_LSB]))
          && (msg_trigger == $past(st_q.defs[0][DEF_TRIG_BIT]))
          && (msg_vector == $past(st_q.defs[0][DEF_VEC_MSB:DEF_VEC_LSB]));
  endproperty
  a_msg_fields: assert property (p_msg_fields) else $error("bad fields");

  property p_msg_release;
    @(posedge clock) disable iff (!reset_n)
      (msg_valid && msg_ready) |=> !msg_valid;
  endproperty
  a_msg_release: assert property (p_msg_release) else $error("message sent twice");

  property p_index_warm;
    @(posedge clock) disable iff (!reset_n)
      (warm_reset && !reg_wr) |=> (st_q.index == $past(st_q.index));
  endproperty
  a_index_warm: assert property (p_index_warm) else $error("index lost on warm reset");

  property p_enable_all;
    @(posedge clock) disable iff (!reset_n)
      (st_q.pend & ~$past(st_q.pend) & ~$past(en_vec)) == 8'h00;
  endproperty
  a_enable_all: assert property (p_enable_all) else $error("disabled pin set pending");

  c_msg_accept:   cover property (@(posedge clock) disable iff (!reset_n) msg_valid && msg_ready);
  c_msg_stall:    cover property (@(posedge clock) disable iff (!reset_n)
                                  msg_valid && !msg_ready ##1 msg_valid && msg_ready);
  c_window_write: cover property (@(posedge clock) disable iff (!reset_n)
                                  reg_wr && reg_addr == OFS_DATA_WIN && lim_is_generic(mode));
  c_legacy_write: cover property (@(posedge clock) disable iff (!reset_n)
                                  reg_wr && lim_def_hit(reg_addr) && lim_is_legacy(mode));
  c_warm:         cover property (@(posedge clock) disable iff (!reset_n) warm_reset);

endmodule : lim_top

`default_nettype wire

/* tb/lim_host_model.sv */
`timescale 1ns/10ps
`default_nettype none

module lim_host_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  // Message link
  input  wire logic        msg_valid,
  input  wire logic [16:0] msg_bits,
  output logic             msg_ready,
  // Bench control and capture
  input  wire logic        stall,
  output logic      [16:0] acc_msg,
  output int               acc_cnt
);
  // Ready is registered, so a stall takes hold one edge late, as a real sink would
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      msg_ready <= 1'b0;
      acc_msg   <= '0;
      acc_cnt   <= 0;
    end else begin
      msg_ready <= ~stall;
      if (msg_valid && msg_ready) begin
        acc_msg <= msg_bits;
        acc_cnt <= acc_cnt + 1;
      end
    end
  end
endmodule : lim_host_model

`default_nettype wire

/* tb/lim_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

module lim_tb_top
  import lim_pkg::*;
;
  logic        clock, reset_n, warm_reset, reg_wr, reg_rd, stall;
  logic        msg_valid, msg_ready, msg_dest_mode, msg_trigger;
  lim_mode_t   mode;
  logic [7:0]  reg_addr, irq_pin, msg_dest_id;
  logic [31:0] reg_wdata, reg_rdata;
  logic [2:0]  msg_pin;
  logic [1:0]  msg_type, msg_vector;
  logic [16:0] bits, acc_msg;
  int          acc_cnt, failures, checks;

  assign bits = {msg_pin, msg_dest_mode, msg_dest_id, msg_type, msg_trigger, msg_vector};

  lim_top i_lim_top (.clock(clock), .reset_n(reset_n), .warm_reset(warm_reset), .mode(mode),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq_pin(irq_pin), .msg_valid(msg_valid), .msg_ready(msg_ready),
    .msg_pin(msg_pin), .msg_dest_mode(msg_dest_mode), .msg_dest_id(msg_dest_id),
    .msg_type(msg_type), .msg_trigger(msg_trigger), .msg_vector(msg_vector));

  lim_host_model i_lim_host_model (.clock(clock), .reset_n(reset_n), .msg_valid(msg_valid),
    .msg_bits(bits), .msg_ready(msg_ready), .stall(stall), .acc_msg(acc_msg),
    .acc_cnt(acc_cnt));

  // ------------------------------------------------------------------
  // Checking and bus tasks
  // ------------------------------------------------------------------
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t register got %h want %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_msg(input logic [16:0] got, input logic [16:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t message got %h want %h", $time, got, exp);
    end
  endtask : chk_msg

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    @(negedge clock);
    chk_reg(reg_rdata, exp);
  endtask : rd

  task automatic set_mode(input lim_mode_t m);
    @(posedge clock);
    mode <= m;
  endtask : set_mode

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    rd(OFS_DEF_BASE, {DEF_RESET, DEF_RESET});
    rd(OFS_CAP_HDR, 32'h0);
    rd(8'ha2, 32'h0);
  endtask : t_reset

  task automatic t_map();
    set_mode(legacy_dual_mode);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_DEF_BASE + 8'(4 * i), {16'h1230 + 16'(i), 16'h0a50 + 16'(i)});
    end
    for (int i = 0; i < 4; i++) begin
      rd(OFS_DEF_BASE + 8'(4 * i), {16'h1230 + 16'(i), 16'h0a50 + 16'(i)});
    end
    set_mode(generic_single_mode);
    rd(OFS_DEF_BASE, 32'h0);
    wr(OFS_DEF_BASE, 32'h0);
    set_mode(legacy_single_mode);
    rd(OFS_DEF_BASE, 32'h12300a50);
  endtask : t_map

  task automatic t_generic();
    wr(OFS_CAP_HDR, 32'h00050000);
    set_mode(generic_dual_mode);
    rd(OFS_CAP_HDR, 32'h8000b408);
    wr(OFS_CAP_HDR, 32'h0007ffff);
    rd(OFS_CAP_HDR, 32'h8007b408);
    wr(OFS_DATA_WIN, 32'hffff0040);
    rd(OFS_DATA_WIN, 32'h00000040);
    wr(OFS_CAP_HDR, 32'h00080000);
    rd(OFS_DATA_WIN, 32'h0);
    set_mode(legacy_single_mode);
    rd(8'hac, 32'h00400a53);
  endtask : t_generic

  // Pin k gets type k and vector 3-k, so every code of both fields is sent
  task automatic t_msg();
    logic [15:0] d;
    logic [16:0] e;
    int          c;
    for (int k = 0; k < 4; k++) begin
      d = {2'b11, 8'h55 + 8'(k), 2'(k), 2'b11, 2'(3 - k)};
      e = {3'(k), 1'b1, 8'h55 + 8'(k), 2'(k), 1'b1, 2'(3 - k)};
      @(posedge clock) stall <= (k == 0);
      wr(OFS_DEF_BASE + 8'(4 * (k / 2)), (k % 2 == 1) ? {d, DEF_RESET} : {DEF_RESET, d});
      c = acc_cnt;
      @(posedge clock) irq_pin[k] <= 1'b1;
      if (k == 0) begin
        repeat (8) @(posedge clock);
        @(negedge clock);
        chk_msg(bits, e);
        chk_reg({31'h0, msg_valid}, 32'h1);
        @(posedge clock) stall <= 1'b0;
      end
      for (int t = 0; t < 20 && acc_cnt == c; t++) @(posedge clock);
      repeat (4) @(posedge clock);
      chk_msg(acc_msg, e);
      chk_reg(32'(acc_cnt - c), 32'h1);
      @(posedge clock) irq_pin[k] <= 1'b0;
    end
  endtask : t_msg

  task automatic t_warm();
    int c;
    @(posedge clock) warm_reset <= 1'b1;
    @(posedge clock) warm_reset <= 1'b0;
    // Pin 3 was d63c; only enable, destination mode, destination and polarity survive
    rd(OFS_DEF_BASE + 8'h04, 32'hd6083fc0);
    c = acc_cnt;
    @(posedge clock) irq_pin[3] <= 1'b1;
    for (int t = 0; t < 20 && acc_cnt == c; t++) @(posedge clock);
    chk_msg(acc_msg, {3'd3, 1'b1, 8'h58, 2'b00, 1'b0, 2'b00});
  endtask : t_warm

  // Active-low pin 4 sends once; pin 5, disabled, toggles alongside and stays quiet
  task automatic t_pol();
    int c;
    wr(OFS_DEF_BASE + 8'h08, {DEF_RESET, 1'b1, 1'b0, 8'ha5, 2'b10, 1'b0, 1'b1, 2'b01});
    c = acc_cnt;
    @(posedge clock) irq_pin[5:4] <= 2'b11;
    repeat (4) @(posedge clock);
    chk_reg(32'(acc_cnt - c), 32'h0);
    @(posedge clock) irq_pin[5:4] <= 2'b00;
    repeat (20) @(posedge clock);
    chk_msg(acc_msg, {3'd4, 1'b0, 8'ha5, 2'b10, 1'b1, 2'b01});
    chk_reg(32'(acc_cnt - c), 32'h1);
  endtask : t_pol

  task automatic end_sim();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  // ------------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Whole run needs well under a thousand cycles; this allows twenty thousand
  initial begin
    #2000000;
    failures++;
    end_sim();
  end

  initial begin
    failures   = 0;
    checks     = 0;
    reset_n    = 1'b0;
    warm_reset = 1'b0;
    mode       = legacy_single_mode;
    reg_addr   = 8'h00;
    reg_wdata  = 32'h0;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    irq_pin    = 8'h00;
    stall      = 1'b0;
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    t_reset();
    t_map();
    t_generic();
    t_msg();
    t_warm();
    t_pol();
    end_sim();
  end
endmodule : lim_tb_top

`default_nettype wire
